// [hw/pbc_basic_control.sv]
`timescale 1ns/1ps
module pbc_basic_control
    import pbc_pkg::*;
(
    input  wire logic       mclk_in,            // Device clock, 20 MHz
    input  wire logic       reset_in,           // Async hardware reset, active high
    // Management pins
    input  wire logic       mdc_in,             // Management clock pin
    input  wire logic       mdio_in,            // Management data pin level
    output logic            mdio_out,           // Management data drive value
    output logic            mdio_oe_out,        // High while driving data pin
    // Configuration straps
    input  wire logic       speed_strap_pin_in, // High selects 100 Mbps default
    input  wire logic       negotiation_enable_strap_pin_in, // Negotiation default
    input  wire logic       isolate_strap_pin_in, // Isolation default
    input  wire logic       duplex_strap_pin_in,  // Inverted duplex default
    input  wire logic [4:0] phy_addr_strap_in,  // Own management address
    // Negotiation result, same clock domain
    input  wire logic       an_speed_100_in,    // Negotiated 100 Mbps
    input  wire logic       an_full_duplex_in,  // Negotiated full duplex
    // Mode controls to the transceiver
    output logic            soft_reset_out,     // Internal reset active
    output logic            an_restart_out,     // One-cycle restart pulse
    output logic            an_enable_out,
    output logic            speed_100_out,      // Effective operating speed
    output logic            full_duplex_out,    // Effective operating duplex
    output logic            loopback_out,
    output logic            power_down_out,
    output logic            isolate_out,
    output logic            col_test_out
);
    import pbc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 11;             // mdc, mdio, four straps, address
    logic [SYNC_W-1:0] meta_q;              // First stage, read only by sync_q
    logic [SYNC_W-1:0] sync_q;              // Second stage
    logic [SYNC_W-1:0] pins;
    logic              mdc_prev_q;          // For edge detection
    logic              mdc_rise;

    assign pins = {mdc_in, mdio_in, speed_strap_pin_in,
                   negotiation_enable_strap_pin_in, isolate_strap_pin_in,
                   duplex_strap_pin_in, phy_addr_strap_in};

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q     <= '0;
            sync_q     <= '0;
            mdc_prev_q <= 1'b0;
        end else begin
            meta_q     <= pins;
            sync_q     <= meta_q;
            mdc_prev_q <= sync_q[10];
        end
    end

    // Management clock is far slower than mclk, so a sampled edge is safe
    assign mdc_rise = sync_q[10] & ~mdc_prev_q;

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    pbc_reg_if bus ();
    logic [4:0] phy_addr_q;                 // Address latched with straps

    pbc_mdio_engine u_engine (
        .mclk_in      (mclk_in),
        .reset_in     (reset_in),
        .mdc_rise_in  (mdc_rise),
        .mdio_sync_in (sync_q[9]),
        .phy_addr_in  (phy_addr_q),
        .mdio_out     (mdio_out),
        .mdio_oe_out  (mdio_oe_out),
        .bus          (bus)
    );

    // ------------------------------------------------------------
    // Control register fields and reset sequencer
    // ------------------------------------------------------------
    pbc_seq_state_t seq_q, seq_d;           // Reset sequence position
    logic [7:0]     seq_cnt_q, seq_cnt_d;   // Cycles in LOAD or HOLD
    logic           srst_q, srst_d;         // Reset bit as read back
    logic           loop_q, loop_d;
    logic           spd_q, spd_d;
    logic           ane_q, ane_d;
    logic           pd_q, pd_d;
    logic           iso_q, iso_d;
    logic           rst_an_q, rst_an_d;     // Restart bit as read back
    logic           dup_q, dup_d;
    logic           col_q, col_d;
    logic           pulse_q, pulse_d;       // Restart pulse to negotiation
    logic [4:0]     paddr_d;
    logic           wr_hit;                 // Write to this register, accepted
    logic [15:0]    ctrl_word;

    // Writes only land in normal operation; the device is in reset otherwise
    assign wr_hit = bus.wr_stb && (bus.addr == REG_BASIC_CONTROL) && (seq_q == SQ_RUN);

    // Next values of the register and of the sequencer
    always_comb begin
        seq_d     = seq_q;
        seq_cnt_d = seq_cnt_q;
        srst_d    = srst_q;
        loop_d    = loop_q;
        spd_d     = spd_q;
        ane_d     = ane_q;
        pd_d      = pd_q;
        iso_d     = iso_q;
        rst_an_d  = rst_an_q;
        dup_d     = dup_q;
        col_d     = col_q;
        pulse_d   = 1'b0;
        paddr_d   = phy_addr_q;
        case (seq_q)
            SQ_LOAD: begin
                // Latch straps once the synchronisers hold real pin levels
                seq_cnt_d = seq_cnt_q + 8'h01;
                if (seq_cnt_q == STRAP_SETTLE_CYC) begin
                    seq_d     = SQ_RUN;
                    seq_cnt_d = 8'h00;
                    srst_d    = 1'b0;
                    loop_d    = RESET_ZERO_BIT;
                    spd_d     = sync_q[8];
                    ane_d     = sync_q[7];
                    pd_d      = RESET_ZERO_BIT;
                    iso_d     = sync_q[6];
                    rst_an_d  = RESET_ZERO_BIT;
                    dup_d     = ~sync_q[5];
                    col_d     = RESET_ZERO_BIT;
                    paddr_d   = sync_q[4:0];
                end
            end
            SQ_RUN: begin
                // Restart bit clears itself after one pulse
                if (rst_an_q) begin
                    rst_an_d = 1'b0;
                    pulse_d  = 1'b1;
                end
                if (wr_hit) begin
                    if (bus.wr_data[BIT_SOFT_RESET] && pd_q) begin
                        // First reset while powered down only wakes the device
                        pd_d = 1'b0;
                    end else if (bus.wr_data[BIT_SOFT_RESET]) begin
                        // Full reset; straps are latched again on the way out
                        srst_d    = 1'b1;
                        seq_d     = SQ_HOLD;
                        seq_cnt_d = 8'h00;
                    end else begin
                        loop_d = bus.wr_data[BIT_LOOPBACK];
                        spd_d  = bus.wr_data[BIT_SPEED_100];
                        ane_d  = bus.wr_data[BIT_AN_ENABLE];
                        pd_d   = bus.wr_data[BIT_POWER_DOWN];
                        iso_d  = bus.wr_data[BIT_ISOLATE];
                        dup_d  = bus.wr_data[BIT_FULL_DUPLEX];
                        col_d  = bus.wr_data[BIT_COL_TEST];
                        // Set wins over the self-clear in the same cycle
                        if (bus.wr_data[BIT_AN_RESTART]) begin
                            rst_an_d = 1'b1;
                        end
                    end
                end
            end
            SQ_HOLD: begin
                // Hold the transceiver in reset for the full pulse
                seq_cnt_d = seq_cnt_q + 8'h01;
                if (seq_cnt_q == SRST_HOLD_CYC - 8'h01) begin
                    seq_d     = SQ_LOAD;
                    seq_cnt_d = 8'h00;
                end
            end
            default: begin
                seq_d     = SQ_LOAD;
                seq_cnt_d = 8'h00;
            end
        endcase
    end

    // Register and sequencer flops; reset values are constants only
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            seq_q      <= SQ_LOAD;
            seq_cnt_q  <= 8'h00;
            srst_q     <= 1'b0;
            loop_q     <= 1'b0;
            spd_q      <= 1'b0;
            ane_q      <= 1'b0;
            pd_q       <= 1'b0;
            iso_q      <= 1'b0;
            rst_an_q   <= 1'b0;
            dup_q      <= 1'b0;
            col_q      <= 1'b0;
            pulse_q    <= 1'b0;
            phy_addr_q <= 5'h00;
        end else begin
            seq_q      <= seq_d;
            seq_cnt_q  <= seq_cnt_d;
            srst_q     <= srst_d;
            loop_q     <= loop_d;
            spd_q      <= spd_d;
            ane_q      <= ane_d;
            pd_q       <= pd_d;
            iso_q      <= iso_d;
            rst_an_q   <= rst_an_d;
            dup_q      <= dup_d;
            col_q      <= col_d;
            pulse_q    <= pulse_d;
            phy_addr_q <= paddr_d;
        end
    end

    // ------------------------------------------------------------
    // Read-back word
    // ------------------------------------------------------------
    // Low seven bits are tied to zero, writes to them have nowhere to go
    assign ctrl_word = {srst_q, loop_q, spd_q, ane_q, pd_q, iso_q, rst_an_q,
                        dup_q, col_q, 7'h00};

    // Other registers of the device live elsewhere and read as zero here
    assign bus.rd_data = (bus.addr == REG_BASIC_CONTROL) ? ctrl_word : 16'h0000;

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    logic so_q, ane_o_q, spd_o_q, dup_o_q, loop_o_q, pd_o_q, iso_o_q, col_o_q;

    // Registered so every mode output comes straight from a flop
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            so_q     <= 1'b1;
            ane_o_q  <= 1'b0;
            spd_o_q  <= 1'b0;
            dup_o_q  <= 1'b0;
            loop_o_q <= 1'b0;
            pd_o_q   <= 1'b0;
            iso_o_q  <= 1'b0;
            col_o_q  <= 1'b0;
        end else begin
            so_q     <= (seq_d != SQ_RUN);
            ane_o_q  <= ane_d;
            // Negotiated result overrides the register while enabled
            spd_o_q  <= ane_d ? an_speed_100_in : spd_d;
            dup_o_q  <= ane_d ? an_full_duplex_in : dup_d;
            loop_o_q <= loop_d;
            pd_o_q   <= pd_d;
            iso_o_q  <= iso_d;
            col_o_q  <= col_d;
        end
    end

    assign soft_reset_out  = so_q;
    assign an_restart_out  = pulse_q;
    assign an_enable_out   = ane_o_q;
    assign speed_100_out   = spd_o_q;
    assign full_duplex_out = dup_o_q;
    assign loopback_out    = loop_o_q;
    assign power_down_out  = pd_o_q;
    assign isolate_out     = iso_o_q;
    assign col_test_out    = col_o_q;

endmodule : pbc_basic_control

// [hw/pbc_pkg.sv]
// Operation
// - Reset bit resets device, then self-clears
// - Restart negotiation bit restarts, then self-clears
// - Speed bit picks 100/10 when negotiation off
// - Negotiation enabled: negotiated speed/duplex take precedence
// - Power-down bit enters and leaves power-down
// - In power-down, first reset only clears it
// - Isolate bit disconnects the MAC data interface
// - Duplex bit: full/half; resets to inverse strap
// - Speed bit resets to speed strap level
// - Negotiation enable resets to its strap level
// - Isolate bit resets to isolation strap level
// - Collision test bit enables collision output test
package pbc_pkg;

    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;   // Register index on management bus
    localparam int         BIT_SOFT_RESET    = 15;      // Self-clearing reset
    localparam int         BIT_LOOPBACK      = 14;
    localparam int         BIT_SPEED_100     = 13;
    localparam int         BIT_AN_ENABLE     = 12;
    localparam int         BIT_POWER_DOWN    = 11;
    localparam int         BIT_ISOLATE       = 10;
    localparam int         BIT_AN_RESTART    = 9;       // Self-clearing restart
    localparam int         BIT_FULL_DUPLEX   = 8;
    localparam int         BIT_COL_TEST      = 7;
    localparam logic       RESET_ZERO_BIT    = 1'b0;    // Reset value of fields that start at zero

    // ------------------------------------------------------------
    // Management frame layout
    // ------------------------------------------------------------
    localparam logic [5:0] MDIO_PRE_LEN   = 6'h20;      // 32 ones of preamble
    localparam logic [5:0] MDIO_HDR_BITS  = 6'h0c;      // Op, phy address, register address
    localparam logic [5:0] MDIO_DATA_BITS = 6'h10;      // Data word length
    localparam logic [5:0] MDIO_TA_LAST   = 6'h01;      // Second turnaround bit index
    localparam logic [1:0] MDIO_OP_READ   = 2'h2;
    localparam logic [1:0] MDIO_OP_WRITE  = 2'h1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 50;      // 20 MHz device clock
    localparam int unsigned SRST_HOLD_NS     = 500;     // Internal reset pulse length
    localparam logic [7:0]  SRST_HOLD_CYC    =
        8'((SRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0]  STRAP_SETTLE_CYC = 8'h03;   // Lets strap synchronisers fill

    // ------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MS_PRE   = 3'b000,
        MS_ST    = 3'b001,
        MS_HDR   = 3'b010,
        MS_TA_RD = 3'b011,
        MS_RD    = 3'b100,
        MS_TA_WR = 3'b101,
        MS_WR    = 3'b110
    } pbc_mdio_state_t;

    typedef enum logic [1:0] {
        SQ_LOAD = 2'b00,    // Waiting to latch straps
        SQ_RUN  = 2'b01,    // Normal operation
        SQ_HOLD = 2'b10     // Software reset in progress
    } pbc_seq_state_t;

endpackage : pbc_pkg

// [hw/pbc_reg_if.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register access between frame engine and register bank
// ------------------------------------------------------------
interface pbc_reg_if;
    logic [4:0]  addr;      // Register index of current frame
    logic        wr_stb;    // One-cycle write strobe
    logic [15:0] wr_data;   // Write word, valid with strobe
    logic [15:0] rd_data;   // Read word for addr

    modport engine (output addr, output wr_stb, output wr_data, input rd_data);
    modport regs   (input addr, input wr_stb, input wr_data, output rd_data);
endinterface : pbc_reg_if

// [hw/pbc_mdio_engine.sv]
`timescale 1ns/1ps
module pbc_mdio_engine
    import pbc_pkg::*;
(
    input  wire logic  mclk_in,         // Device clock
    input  wire logic  reset_in,        // Async reset, active high
    input  wire logic  mdc_rise_in,     // Rising edge of synchronised management clock
    input  wire logic  mdio_sync_in,    // Synchronised data pin
    input  wire logic  [4:0] phy_addr_in, // Latched own address
    output logic       mdio_out,        // Data pin drive value
    output logic       mdio_oe_out,     // High while driving the pin
    pbc_reg_if.engine  bus
);
    import pbc_pkg::*;

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    pbc_mdio_state_t st_q, st_d;        // Frame position
    logic [5:0]      cnt_q, cnt_d;      // Bit counter
    logic [15:0]     sh_q, sh_d;        // Shift register
    logic [4:0]      addr_q, addr_d;    // Register index
    logic            out_q, out_d;
    logic            oe_q, oe_d;
    logic            wr_q, wr_d;
    logic [11:0]     hdr;               // Header including newest bit

    assign hdr = {sh_q[10:0], mdio_sync_in};

    // Next frame state, advanced only on management clock edges
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        sh_d   = sh_q;
        addr_d = addr_q;
        out_d  = out_q;
        oe_d   = oe_q;
        wr_d   = 1'b0;
        if (mdc_rise_in) begin
            case (st_q)
                MS_PRE: begin
                    // Data ones can never reach 32, so no false frame start
                    if (mdio_sync_in) begin
                        cnt_d = (cnt_q == MDIO_PRE_LEN) ? cnt_q : cnt_q + 6'h01;
                    end else if (cnt_q == MDIO_PRE_LEN) begin
                        st_d  = MS_ST;
                        cnt_d = 6'h00;
                    end else begin
                        cnt_d = 6'h00;
                    end
                end
                MS_ST: begin
                    st_d  = mdio_sync_in ? MS_HDR : MS_PRE;
                    cnt_d = 6'h00;
                end
                MS_HDR: begin
                    sh_d  = {sh_q[14:0], mdio_sync_in};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == MDIO_HDR_BITS - 6'h01) begin
                        cnt_d  = 6'h00;
                        addr_d = hdr[4:0];
                        if (hdr[9:5] != phy_addr_in) begin
                            st_d = MS_PRE;      // Frame for another device
                        end else if (hdr[11:10] == MDIO_OP_READ) begin
                            st_d = MS_TA_RD;
                        end else if (hdr[11:10] == MDIO_OP_WRITE) begin
                            st_d = MS_TA_WR;
                        end else begin
                            st_d = MS_PRE;
                        end
                    end
                end
                MS_TA_RD: begin
                    // Drive the zero turnaround bit, capture read word
                    oe_d  = 1'b1;
                    out_d = 1'b0;
                    sh_d  = bus.rd_data;
                    st_d  = MS_RD;
                    cnt_d = 6'h00;
                end
                MS_RD: begin
                    if (cnt_q == MDIO_DATA_BITS) begin
                        oe_d  = 1'b0;           // Release after last bit
                        out_d = 1'b0;
                        st_d  = MS_PRE;
                        cnt_d = 6'h00;
                    end else begin
                        out_d = sh_q[15];
                        sh_d  = {sh_q[14:0], 1'b0};
                        cnt_d = cnt_q + 6'h01;
                    end
                end
                MS_TA_WR: begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == MDIO_TA_LAST) begin
                        st_d  = MS_WR;
                        cnt_d = 6'h00;
                    end
                end
                MS_WR: begin
                    sh_d  = {sh_q[14:0], mdio_sync_in};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == MDIO_DATA_BITS - 6'h01) begin
                        wr_d  = 1'b1;
                        st_d  = MS_PRE;
                        cnt_d = 6'h00;
                    end
                end
                default: begin
                    st_d  = MS_PRE;
                    cnt_d = 6'h00;
                    oe_d  = 1'b0;
                end
            endcase
        end
    end

    // Frame registers
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q   <= MS_PRE;
            cnt_q  <= 6'h00;
            sh_q   <= 16'h0000;
            addr_q <= 5'h00;
            out_q  <= 1'b0;
            oe_q   <= 1'b0;
            wr_q   <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            sh_q   <= sh_d;
            addr_q <= addr_d;
            out_q  <= out_d;
            oe_q   <= oe_d;
            wr_q   <= wr_d;
        end
    end

    assign mdio_out    = out_q;
    assign mdio_oe_out = oe_q;
    assign bus.addr    = addr_q;
    assign bus.wr_stb  = wr_q;
    assign bus.wr_data = sh_q;

endmodule : pbc_mdio_engine

// [tb/pbc_asserts.sv]
`timescale 1ns/1ps
module pbc_asserts (
    input wire logic mclk_in, reset_in, soft_reset_out, an_restart_out, an_enable_out,
    input wire logic negotiation_enable_strap_pin_in, isolate_strap_pin_in, isolate_out,
    input wire logic power_down_out, loopback_out, col_test_out, speed_100_out, an_speed_100_in
);
    // ------------------------------------------------------------
    // Mode control checks, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);
    property p_rs_one; an_restart_out |=> !an_restart_out; endproperty
    a_rs_one: assert property (p_rs_one) else $error("restart pulse too long");
    property p_sr_hold; $rose(soft_reset_out) |-> soft_reset_out [*8]; endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("reset pulse short");
    property p_sr_end; soft_reset_out |-> ##[0:40] !soft_reset_out; endproperty
    a_sr_end: assert property (p_sr_end) else $error("reset never clears");
    property p_an_strap;
        $fell(soft_reset_out) |-> an_enable_out == negotiation_enable_strap_pin_in;
    endproperty
    a_an_strap: assert property (p_an_strap) else $error("enable not strapped");
    property p_iso_strap; $fell(soft_reset_out) |-> isolate_out == isolate_strap_pin_in; endproperty
    a_iso_strap: assert property (p_iso_strap) else $error("isolate not strapped");
    property p_zeros; $fell(soft_reset_out) |-> !(power_down_out | loopback_out | col_test_out);
    endproperty
    a_zeros: assert property (p_zeros) else $error("mode bit set at reset");
    // Negotiated speed wins once both enable and result have settled
    property p_an_spd;
        !soft_reset_out && !$past(soft_reset_out) && an_enable_out && $past(an_enable_out)
            && $stable(an_speed_100_in) |-> speed_100_out == an_speed_100_in;
    endproperty
    a_an_spd: assert property (p_an_spd) else $error("speed not negotiated");
    property p_pd_exit; $fell(power_down_out) |-> !soft_reset_out [*4]; endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("reset on leaving power-down");
    c_pd: cover property ($fell(power_down_out));
    c_rs: cover property (an_restart_out);
    c_sr: cover property ($rose(soft_reset_out));
endmodule : pbc_asserts
bind pbc_basic_control pbc_asserts u_chk (.*);

// [tb/pbc_mdio_master.sv]
`timescale 1ns/1ps
module pbc_mdio_master #(
    parameter logic [4:0] PHY_ADDR = 5'h03
) (
    input  wire logic mclk_in,
    input  wire logic line_in,  // Resolved data line
    output logic      mdc_out,  // Stands low between frames
    output logic      drv_out,
    output logic      oe_out
);
    int half = 5;  // Cycles per clock half; raised to act as a slow controller
    initial begin
        mdc_out = 1'b0;
        drv_out = 1'b1;
        oe_out  = 1'b0;
    end
    // One clock; line sampled just before the rising edge
    task automatic bit_cyc(input logic b, input logic oe, output logic s);
        drv_out <= b;
        oe_out  <= oe;
        repeat (half) @(posedge mclk_in);
        s = line_in;
        mdc_out <= 1'b1;
        repeat (half) @(posedge mclk_in);
        mdc_out <= 1'b0;
    endtask : bit_cyc
    // Full frame; released from turnaround on when reading
    task automatic frame(input logic rd, input logic [4:0] rg, input logic [15:0] wd,
                         output logic [15:0] q);
        logic [31:0] w;
        logic        s;
        w = {2'b01, rd ? 2'b10 : 2'b01, PHY_ADDR, rg, rd ? 2'b11 : 2'b10, wd};
        for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
        for (int i = 31; i >= 0; i--) begin
            bit_cyc(w[i], i > 17 || !rd, s);
            if (i < 16) q[i] = s;
        end
        oe_out <= 1'b0;
        repeat (20) @(posedge mclk_in);
    endtask : frame
endmodule : pbc_mdio_master

// [tb/pbc_basic_control_tb.sv]
`timescale 1ns/1ps
module pbc_basic_control_tb;
    logic mclk_in = 1'b0, reset_in = 1'b1, spd = 1'b1, neg = 1'b0, iso = 1'b1, dup = 1'b1;
    logic an_spd = 1'b1, an_dup = 1'b1, sr_prev = 1'b1;
    logic mdc, mdrv, moe, dout, doe, mdio, sr_o, rs_o, an_o, spd_o, dup_o, lb_o, pd_o, iso_o, ct_o;
    logic [15:0] q;
    int num_errors = 0, total_checks = 0, cyc = 0, sr_n = 0, rs_n = 0, n;
    always #25 mclk_in = ~mclk_in;
    assign mdio = doe ? dout : (moe ? mdrv : 1'b1);  // Pull-up when nobody drives
    pbc_mdio_master m (.mclk_in(mclk_in), .line_in(mdio), .mdc_out(mdc), .drv_out(mdrv),
                       .oe_out(moe));
    pbc_basic_control uut (.mclk_in(mclk_in), .reset_in(reset_in), .mdc_in(mdc), .mdio_in(mdio),
        .mdio_out(dout), .mdio_oe_out(doe), .speed_strap_pin_in(spd),
        .negotiation_enable_strap_pin_in(neg), .isolate_strap_pin_in(iso),
        .duplex_strap_pin_in(dup), .phy_addr_strap_in(5'h03), .an_speed_100_in(an_spd),
        .an_full_duplex_in(an_dup), .soft_reset_out(sr_o), .an_restart_out(rs_o),
        .an_enable_out(an_o), .speed_100_out(spd_o), .full_duplex_out(dup_o),
        .loopback_out(lb_o), .power_down_out(pd_o), .isolate_out(iso_o), .col_test_out(ct_o));
    // Event counters and hang guard
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        sr_prev <= sr_o;
        if (sr_o && !sr_prev) sr_n <= sr_n + 1;
        if (rs_o === 1'b1) rs_n <= rs_n + 1;
        if (cyc == 20000) begin
            num_errors += 1;
            close_out();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] v); m.frame(1'b0, 5'h00, v, q); endtask : wr
    task automatic rd(input logic [4:0] r); m.frame(1'b1, r, 16'h0000, q); endtask : rd
    task automatic t_reset;
        rd(5'h00); chk(q, 16'h2400);
        rd(5'h01); chk(q, 16'h0000);
    endtask : t_reset
    task automatic t_fields;
        wr(16'h41ff); rd(5'h00); chk(q, 16'h4180);
        chk({lb_o, spd_o, dup_o, iso_o, ct_o}, 5'b10101);
        m.half = 8;  // Slow controller
        wr(16'h2000); chk({lb_o, spd_o, dup_o, ct_o}, 4'b0100);
        m.half = 5;
    endtask : t_fields
    task automatic t_an;
        n = rs_n;
        wr(16'h1200); chk(rs_n - n, 1);
        rd(5'h00); chk(q, 16'h1000);
        chk({an_o, spd_o, dup_o}, 3'b111);
    endtask : t_an
    task automatic t_pd;
        wr(16'h0800); chk(pd_o, 1'b1);
        n = sr_n;
        wr(16'h8000); chk({pd_o, 15'(sr_n - n)}, 16'h0000);
        rd(5'h00); chk(q, 16'h0000);
        @(posedge mclk_in);
        neg <= 1'b1;
        wr(16'h8000);
        chk(sr_n - n, 1);
        rd(5'h00); chk(q, 16'h3400);
    endtask : t_pd
    task automatic close_out;
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (6) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (10) @(posedge mclk_in);
        t_reset();
        t_fields();
        t_an();
        t_pd();
        close_out();
    end
endmodule : pbc_basic_control_tb
